// *** rtl/half_bridge_pwm.sv ***
// Half-bridge PWM with dead band, auto-shutdown and restart, behind AHB-Lite.
// Assumes a single 40 MHz clock, synchronous inputs and one AHB master.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - Delay only inactive-to-active output transitions
// - Seven-bit delay field counts instruction cycles
// - Count equals cycles from schedule to active
// - Auto-restart clears flag when shutdown ends
// - Period boundary when timer equals limit
// - Output A carries PWM, B its complement
// - Overlong delay keeps output inactive all cycle
// - Shutdown is level; flag held while present
// - Resume only at next full period
module half_bridge_pwm #(
   parameter int TIMER_W = 8
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Shutdown source and outputs
   input  wire logic        SHUTDOWN_IN,
   output logic             PWM_OUT_A,
   output logic             PWM_OUT_B,
   output logic             IRQ
);
   dead_band_pkg::dbr_ctrl_t   dbr_r;
   logic [7:0]                 cap_r;
   logic [5:0]                 shut_cfg_r;
   logic                       flag_r;
   logic [TIMER_W-1:0]         limit_r;
   logic [TIMER_W-1:0]         duty_r;
   logic [TIMER_W-1:0]         timer_r;
   logic [1:0]                 pre_r;
   logic [dead_band_pkg::IRQ_BITS-1:0] stat_r;
   logic [dead_band_pkg::IRQ_BITS-1:0] mask_r;
   logic [dead_band_pkg::IRQ_BITS-1:0] ev;
   dead_band_pkg::run_state_t  state_r;
   dead_band_pkg::pwm_pair_t   raw, dly, out_r;
   logic                       wr_pend_r;
   logic                       rd_stat_r;
   logic [7:0]                 addr_r;
   logic                       tick, period_end, period_start, sw_clear, sw_set, half, pwm;

   // ==========================================================================
   // Address phase capture
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   wire acc = HSEL && HREADY && HTRANS[1];

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else begin
         wr_pend_r <= acc && HWRITE;
         if (acc)
            addr_r <= HADDR[7:0];
      end
   end

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   // ==========================================================================
   // Read mux, zero for unmapped addresses
   always_comb begin
      HRDATA = 32'h0000_0000;
      if (hit(addr_r, dead_band_pkg::DBR_CTRL_ADDR))  HRDATA[7:0] = dbr_r;
      if (hit(addr_r, dead_band_pkg::CAP_CTRL_ADDR))  HRDATA[7:0] = cap_r;
      if (hit(addr_r, dead_band_pkg::SHUT_CTRL_ADDR)) HRDATA[7:0] = {flag_r, 1'b0, shut_cfg_r};
      if (hit(addr_r, dead_band_pkg::PERIOD_ADDR))    HRDATA[TIMER_W-1:0] = limit_r;
      if (hit(addr_r, dead_band_pkg::DUTY_ADDR))      HRDATA[TIMER_W-1:0] = duty_r;
      if (hit(addr_r, dead_band_pkg::IRQ_STAT_ADDR))  HRDATA[dead_band_pkg::IRQ_BITS-1:0] = stat_r;
      if (hit(addr_r, dead_band_pkg::IRQ_MASK_ADDR))  HRDATA[dead_band_pkg::IRQ_BITS-1:0] = mask_r;
      if (hit(addr_r, dead_band_pkg::STATE_ADDR))     HRDATA[TIMER_W-1:0] = timer_r;
   end

   // ==========================================================================
   // Configuration registers
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         dbr_r      <= dead_band_pkg::CTRL_RESET;
         cap_r      <= dead_band_pkg::CTRL_RESET;
         shut_cfg_r <= 6'h00;
         limit_r    <= TIMER_W'(dead_band_pkg::PERIOD_RESET);
         duty_r     <= '0;
         mask_r     <= '0;
      end else if (wr_pend_r) begin
         if (hit(addr_r, dead_band_pkg::DBR_CTRL_ADDR))  dbr_r      <= HWDATA[7:0];
         if (hit(addr_r, dead_band_pkg::CAP_CTRL_ADDR))  cap_r      <= HWDATA[7:0];
         if (hit(addr_r, dead_band_pkg::SHUT_CTRL_ADDR)) shut_cfg_r <= HWDATA[5:0];
         if (hit(addr_r, dead_band_pkg::PERIOD_ADDR))    limit_r    <= HWDATA[TIMER_W-1:0];
         if (hit(addr_r, dead_band_pkg::DUTY_ADDR))      duty_r     <= HWDATA[TIMER_W-1:0];
         if (hit(addr_r, dead_band_pkg::IRQ_MASK_ADDR))
            mask_r <= HWDATA[dead_band_pkg::IRQ_BITS-1:0];
      end
   end

   // ==========================================================================
   // Instruction-cycle prescaler and period timer
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         pre_r <= 2'h0;
      else
         pre_r <= pre_r + 2'h1;
   end
   assign tick = (pre_r == 2'(dead_band_pkg::PRESCALE - 1));
   assign period_end   = tick && (timer_r == limit_r);
   assign period_start = period_end;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         timer_r <= '0;
      else if (period_end)
         timer_r <= '0;
      else if (tick)
         timer_r <= timer_r + TIMER_W'(1);
   end

   // ==========================================================================
   // Shutdown flag; hardware set wins over software clear
   assign sw_clear = wr_pend_r && hit(addr_r, dead_band_pkg::SHUT_CTRL_ADDR)
                     && !HWDATA[dead_band_pkg::SHUT_FLAG_BIT];
   assign sw_set   = wr_pend_r && hit(addr_r, dead_band_pkg::SHUT_CTRL_ADDR)
                     && HWDATA[dead_band_pkg::SHUT_FLAG_BIT];

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         flag_r <= 1'b0;
      else if (SHUTDOWN_IN || sw_set)
         flag_r <= 1'b1;
      else if (dbr_r.auto_restart_enable)
         flag_r <= 1'b0;
      else if (sw_clear)
         flag_r <= 1'b0;
   end

   // ==========================================================================
   // Run state: shutdown, then wait for a fresh period
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         state_r <= dead_band_pkg::WAIT_PERIOD;
      else begin
         case (state_r)
            dead_band_pkg::RUN:
               if (flag_r || SHUTDOWN_IN) state_r <= dead_band_pkg::SHUT;
            dead_band_pkg::SHUT:
               if (!flag_r && !SHUTDOWN_IN) state_r <= dead_band_pkg::WAIT_PERIOD;
            dead_band_pkg::WAIT_PERIOD:
               if (flag_r || SHUTDOWN_IN) state_r <= dead_band_pkg::SHUT;
               else if (period_start) state_r <= dead_band_pkg::RUN;
            default:
               state_r <= dead_band_pkg::SHUT;
         endcase
      end
   end

   // ==========================================================================
   // Raw waveform and dead band per leg
   assign half  = cap_r[dead_band_pkg::HALF_BIT];
   assign pwm   = (timer_r < duty_r);
   assign raw.a = pwm;
   assign raw.b = !pwm;

   dead_band_delay u_leg_a (
      .clk          (SYS_CLK),
      .nrst         (NRST),
      .tick         (tick),
      .period_start (1'b0),
      .count        (half ? dbr_r.dead_band_count : 7'h00),
      .want         (raw.a && state_r == dead_band_pkg::RUN),
      .active       (dly.a)
   );

   dead_band_delay u_leg_b (
      .clk          (SYS_CLK),
      .nrst         (NRST),
      .tick         (tick),
      .period_start (1'b0),
      .count        (half ? dbr_r.dead_band_count : 7'h00),
      .want         (raw.b && half && state_r == dead_band_pkg::RUN),
      .active       (dly.b)
   );

   // Output registers with programmable polarity; shutdown forces inactive
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         out_r <= 2'b00;
      else begin
         out_r.a <= dly.a ^ cap_r[dead_band_pkg::POL_A_BIT];
         out_r.b <= dly.b ^ cap_r[dead_band_pkg::POL_B_BIT];
      end
   end
   assign PWM_OUT_A = out_r.a;
   assign PWM_OUT_B = out_r.b;

   // ==========================================================================
   // Interrupt status, cleared by a read, set wins
   assign ev[dead_band_pkg::IRQ_SHUT]    = flag_r == 1'b0 && SHUTDOWN_IN;
   assign ev[dead_band_pkg::IRQ_RESTART] = state_r == dead_band_pkg::WAIT_PERIOD && period_start;
   assign ev[dead_band_pkg::IRQ_PERIOD]  = period_end;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         rd_stat_r <= 1'b0;
      else
         rd_stat_r <= acc && !HWRITE && hit(HADDR[7:0], dead_band_pkg::IRQ_STAT_ADDR);
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         stat_r <= '0;
      else
         stat_r <= (rd_stat_r ? '0 : stat_r) | ev;
   end

   assign IRQ = |(stat_r & mask_r);
endmodule // half_bridge_pwm

// *** inc/dead_band_pkg.sv ***
// Package: register map, field layout and timing constants of the dead-band and restart block.
// Assumes a single 40 MHz clock and a 32-bit AHB-Lite register bus.
package dead_band_pkg;
   // ==========================================================================
   // Register byte addresses
   localparam logic [7:0] DBR_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] CAP_CTRL_ADDR   = 8'h04;
   localparam logic [7:0] SHUT_CTRL_ADDR  = 8'h08;
   localparam logic [7:0] PERIOD_ADDR     = 8'h0c;
   localparam logic [7:0] DUTY_ADDR       = 8'h10;
   localparam logic [7:0] IRQ_STAT_ADDR   = 8'h14;
   localparam logic [7:0] IRQ_MASK_ADDR   = 8'h18;
   localparam logic [7:0] STATE_ADDR      = 8'h1c;
   // ==========================================================================
   // Reset values
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] PERIOD_RESET    = 8'hff;
   // ==========================================================================
   // Field positions and widths, prescaler ratio
   localparam int RESTART_BIT   = 7;
   localparam int DB_WIDTH      = 7;
   localparam int SHUT_FLAG_BIT = 7;
   localparam int HALF_BIT      = 7;
   localparam int POL_A_BIT     = 1;
   localparam int POL_B_BIT     = 0;
   localparam int PRESCALE      = 4;
   // Interrupt status bits
   localparam int IRQ_SHUT      = 0;
   localparam int IRQ_RESTART   = 1;
   localparam int IRQ_PERIOD    = 2;
   localparam int IRQ_BITS      = 3;

   typedef struct packed {
      logic       auto_restart_enable;
      logic [6:0] dead_band_count;
   } dbr_ctrl_t;

   typedef struct packed {
      logic a;
      logic b;
   } pwm_pair_t;

   typedef enum logic [1:0] {RUN, SHUT, WAIT_PERIOD} run_state_t;
endpackage

// *** rtl/dead_band_delay.sv ***
// One output leg: delays inactive-to-active by a count of instruction cycles.
// Assumes tick pulses once every instruction cycle; the top ties period_start low, so a new period never restarts the delay.
`timescale 1ns/10ps
module dead_band_delay (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Control
   input  wire logic       tick,
   input  wire logic       period_start,
   input  wire logic [6:0] count,
   input  wire logic       want,
   // Result
   output logic            active
);
   logic [6:0] wait_r;

   // ==========================================================================
   // Delay counter, reloaded each time the leg is asked to go inactive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_r <= 7'h00;
      end else if (!want || period_start) begin
         wait_r <= count;
      end else if (tick && wait_r != 7'h00) begin
         wait_r <= wait_r - 7'h01;
      end
   end

   // Active only once wait expired; zero count passes straight through
   // A count longer than the active time never expires before want drops
   assign active = want && (wait_r == 7'h00);
endmodule // dead_band_delay

// *** verification/hb_asserts.sv ***
// ==========================================================================
// Checker: bus answer and leg timing on the half-bridge PWM ports.
// Assumes non-inverted legs and the bind at the foot of this file.
`timescale 1ns/10ps
module hb_asserts (
   // Watched ports
   input wire logic        SYS_CLK,
   input wire logic        NRST,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        SHUTDOWN_IN,
   input wire logic        PWM_OUT_A,
   input wire logic        PWM_OUT_B,
   input wire logic        IRQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   logic unm_r;
   // Data phase of a read outside the map
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST)
         unm_r <= 1'b0;
      else
         unm_r <= HSEL && HREADY && HTRANS[1] && !HWRITE && (HADDR[7:0] >= 8'h20);
   end
   sequence shut_held;
      SHUTDOWN_IN [*3];
   endsequence
   sequence legs_off;
      !PWM_OUT_A && !PWM_OUT_B;
   endsequence
   chk_resp_okay: assert property (HRESP == 1'b0) else $error("error response");
   chk_ready_high: assert property (HREADYOUT) else $error("wait state inserted");
   chk_no_overlap: assert property (!(PWM_OUT_A && PWM_OUT_B)) else $error("legs overlap");
   chk_shut_off: assert property (shut_held |-> legs_off) else $error("leg active");
   chk_release_wait: assert property (shut_held ##1 !SHUTDOWN_IN |-> legs_off ##1 legs_off)
      else $error("leg active right after shutdown");
   chk_unmapped_zero: assert property (unm_r |-> HRDATA == 32'h0) else $error("unmapped read");
   chk_irq_reset: assert property ($rose(NRST) |-> !IRQ) else $error("irq after reset");
   chk_legs_reset: assert property ($rose(NRST) |-> legs_off) else $error("leg after reset");
endmodule // hb_asserts
bind half_bridge_pwm hb_asserts i_hb_asserts (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SHUTDOWN_IN(SHUTDOWN_IN), .PWM_OUT_A(PWM_OUT_A),
   .PWM_OUT_B(PWM_OUT_B), .IRQ(IRQ));

// *** verification/switch_pair.sv ***
// ==========================================================================
// Power switch pair model: flags any cycle with both switches on.
// Assumes active-high gate drives sampled on the system clock.
`timescale 1ns/10ps
module switch_pair (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Gate drives
   input  wire logic gate_hi,
   input  wire logic gate_lo,
   // Sticky shoot-through flag
   output logic      shoot
);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         shoot <= 1'b0;
      else if (gate_hi && gate_lo)
         shoot <= 1'b1;
   end
endmodule // switch_pair

// *** verification/tb.sv ***
// ==========================================================================
// Testbench: registers, dead band, shutdown and restart of the half-bridge PWM.
// Assumes one AHB-Lite slave, answering in its own time, and non-inverted legs.
`timescale 1ns/10ps
module tb;
   localparam int P = 64;
   logic        SYS_CLK = 0, NRST = 0, HSEL = 0, HWRITE = 0, SHUTDOWN_IN = 0;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, q, na, nb;
   logic [1:0]  HTRANS = 0;
   logic [2:0]  HSIZE = 0;
   logic        HREADY, HREADYOUT, HRESP, PWM_OUT_A, PWM_OUT_B, IRQ, shoot;
   int          fails = 0, n_compared = 0, k, dt[4] = '{8, 5, 12, 0}, bt[4] = '{0, 7, 5, 0};
   assign HREADY = HREADYOUT;
   half_bridge_pwm i_half_bridge_pwm (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SHUTDOWN_IN(SHUTDOWN_IN),
      .PWM_OUT_A(PWM_OUT_A), .PWM_OUT_B(PWM_OUT_B), .IRQ(IRQ));
   switch_pair i_switch_pair (.clk(SYS_CLK), .nrst(NRST), .gate_hi(PWM_OUT_A),
      .gate_lo(PWM_OUT_B), .shoot(shoot));
   initial forever #12.5 SYS_CLK = ~SYS_CLK;
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus phase, held until ready is seen at a rising edge; data taken there
   task automatic phase();
      int   n;
      logic rdy;
      n = 0;
      do begin
         @(posedge SYS_CLK);
         rdy = HREADY;
         q = HRDATA;
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin
         fails++;
         print_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      HSIZE <= 3'b010;
      phase();
      HTRANS <= 2'b00;
      HWDATA <= wd;
      phase();
   endtask
   task automatic measure();
      repeat (2 * P) @(posedge SYS_CLK);
      na = 0;
      nb = 0;
      repeat (P) begin
         @(negedge SYS_CLK);
         na += PWM_OUT_A;
         nb += PWM_OUT_B;
      end
      @(posedge SYS_CLK);
   endtask
   function automatic int on_time(int span, int db);
      return span > db ? (span - db) * 4 : 0;
   endfunction
   initial begin
      void'($urandom(20784));
      repeat (4) @(posedge SYS_CLK);
      NRST <= 1'b1;
      @(posedge SYS_CLK);
      bus(0, dead_band_pkg::DBR_CTRL_ADDR, 0);
      check_val(q, 32'h0);
      bus(0, dead_band_pkg::PERIOD_ADDR, 0);
      check_val(q, 32'hff);
      bus(0, 8'h40, 0);
      check_val(q, 32'h0);
      $display("test reset done");
      bus(1, dead_band_pkg::PERIOD_ADDR, P / 4 - 1);
      bus(1, dead_band_pkg::CAP_CTRL_ADDR, 32'h80);
      bus(1, dead_band_pkg::IRQ_MASK_ADDR, 32'h1);
      dt[3] = 2 + $urandom % 12;
      bt[3] = $urandom % 4;
      for (k = 0; k < 4; k++) begin
         bus(1, dead_band_pkg::DUTY_ADDR, dt[k]);
         bus(1, dead_band_pkg::DBR_CTRL_ADDR, bt[k]);
         measure();
         check_val(na, on_time(dt[k], bt[k]));
         check_val(nb, on_time(P / 4 - dt[k], bt[k]));
         $display("test dead band %0d done", k);
      end
      bus(1, dead_band_pkg::DUTY_ADDR, 8);
      bus(1, dead_band_pkg::DBR_CTRL_ADDR, 32'h81);
      SHUTDOWN_IN <= 1'b1;
      repeat (20) @(posedge SYS_CLK);
      bus(0, dead_band_pkg::SHUT_CTRL_ADDR, 0);
      check_val(q[7], 1);
      check_val(IRQ, 1);
      SHUTDOWN_IN <= 1'b0;
      measure();
      check_val(na, on_time(8, 1));
      bus(0, dead_band_pkg::SHUT_CTRL_ADDR, 0);
      check_val(q[7], 0);
      bus(0, dead_band_pkg::IRQ_STAT_ADDR, 0);
      check_val(q[0], 1);
      // Clear lands at the data-phase edge; look one cycle later
      @(posedge SYS_CLK);
      check_val(IRQ, 0);
      $display("test auto restart done");
      bus(1, dead_band_pkg::IRQ_MASK_ADDR, 0);
      bus(1, dead_band_pkg::DBR_CTRL_ADDR, 32'h01);
      SHUTDOWN_IN <= 1'b1;
      repeat (20) @(posedge SYS_CLK);
      check_val(IRQ, 0);
      SHUTDOWN_IN <= 1'b0;
      measure();
      check_val(na + nb, 0);
      bus(0, dead_band_pkg::SHUT_CTRL_ADDR, 0);
      check_val(q[7], 1);
      bus(1, dead_band_pkg::SHUT_CTRL_ADDR, 0);
      measure();
      check_val(na, on_time(8, 1));
      check_val(shoot, 0);
      $display("test software restart done");
      print_verdict();
   end
endmodule // tb
